// ---- hdl/serial_lane_config_pkg.sv ----
// Purpose: constants for the serial lane configuration register bank
// Assumes: 8-bit register addresses and 8-bit data on the serial control port
// Notes: open bits read as zero
package serial_lane_config_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_LANES = 4;
  localparam int MAP_W = 3;
  localparam int OFFSET_W = 5;

  localparam logic [7:0] ADDR_LANE1_CHECKSUM = 8'h79;
  localparam logic [7:0] ADDR_LANE2_CHECKSUM = 8'h7a;
  localparam logic [7:0] ADDR_LANE3_CHECKSUM = 8'h7b;
  localparam logic [7:0] ADDR_LANE_POWER_OFF = 8'h80;
  localparam logic [7:0] ADDR_LANE_MAP_LOW = 8'h82;
  localparam logic [7:0] ADDR_LANE_MAP_HIGH = 8'h83;
  localparam logic [7:0] ADDR_LANE_POLARITY = 8'h86;
  localparam logic [7:0] ADDR_MF_PHASE_OFFSET = 8'h8b;

  localparam logic [3:0] RST_LANE_POWER_OFF = 4'h0;
  localparam logic [7:0] RST_LANE_MAP_LOW = 8'h10;
  localparam logic [7:0] RST_LANE_MAP_HIGH = 8'h32;
  localparam logic [3:0] RST_LANE_POLARITY = 4'h0;
  localparam logic [4:0] RST_MF_PHASE_OFFSET = 5'h00;

  // field positions inside the assignment bytes
  localparam int MAP_LO_FIELD_LSB = 0;
  localparam int MAP_HI_FIELD_LSB = 4;

  // default multiframe length in device clock cycles
  localparam int MF_PERIOD_CYCLES = 32;
endpackage

// ---- hdl/serial_lane_config_regs.sv ----
// Purpose: register bank for lane checksums, lane power-off, lane mapping, polarity and multiframe phase offset
// Assumes: register strobes come already decoded from the serial control port, synchronous to i_clk
// Notes: checksums are the modulo-256 sum of the link parameter fields each lane sends

// Behaviour
// RULE1: lanes 1 to 3 each have a read-only checksum byte and writes to those bytes do nothing.
// RULE2: the power-off byte holds one disable bit per physical lane in bits 3:0, lane 0 at bit 0, all clear at reset.
// RULE3: a set disable bit powers down that lane's serializer and output driver.
// RULE4: each physical lane has a three-bit field choosing logical lane 0 to 3 by codes 000 to 011.
// RULE5: fields sit in bits 6:4 and 2:0 of two bytes, higher lane upper, resetting to 0x10 and 0x32.
// RULE6: the polarity byte holds one invert bit per physical lane in bits 3:0, all clear at reset.
// RULE7: a five-bit phase offset, zero at reset, is loaded into the multiframe clock when SYSREF realigns it.
// RULE8: each lane checksum is the sum of the link parameters that lane sends and follows them when they change.
module serial_lane_config_regs
  import serial_lane_config_pkg::*;
#(
  parameter int MF_PERIOD = MF_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  // link parameters shared by all lanes
  input wire logic [7:0] i_device_id,
  input wire logic [3:0] i_bank_id,
  input wire logic i_scramble,
  input wire logic [4:0] i_lanes_m1,
  input wire logic [7:0] i_octets_m1,
  input wire logic [4:0] i_frames_m1,
  input wire logic [7:0] i_converters_m1,
  input wire logic [1:0] i_control_bits,
  input wire logic [4:0] i_resolution_m1,
  input wire logic [2:0] i_subclass,
  input wire logic [4:0] i_total_bits_m1,
  input wire logic [2:0] i_version,
  input wire logic [4:0] i_samples_m1,
  input wire logic i_high_density,
  input wire logic [4:0] i_control_words,
  // per-lane identifiers
  input wire logic [4:0] i_lane1_id,
  input wire logic [4:0] i_lane2_id,
  input wire logic [4:0] i_lane3_id,
  // multiframe alignment
  input wire logic i_sysref,
  output logic o_mf_boundary,
  // lane controls
  output logic [NUM_LANES-1:0] o_lane_power_down,
  output logic [NUM_LANES-1:0] o_lane_invert,
  output logic [MAP_W-1:0] o_lane0_map,
  output logic [MAP_W-1:0] o_lane1_map,
  output logic [MAP_W-1:0] o_lane2_map,
  output logic [MAP_W-1:0] o_lane3_map
);

  localparam int MF_CNT_W = $clog2(MF_PERIOD);
  localparam logic [MF_CNT_W-1:0] MF_LAST = MF_CNT_W'(MF_PERIOD - 1);

  logic [7:0] chk1_reg;
  logic [7:0] chk2_reg;
  logic [7:0] chk3_reg;
  logic [NUM_LANES-1:0] power_off_reg;
  logic [7:0] map_low_reg;
  logic [7:0] map_high_reg;
  logic [NUM_LANES-1:0] polarity_reg;
  logic [OFFSET_W-1:0] phase_offset_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [MF_CNT_W-1:0] mf_cnt_reg;
  logic [MF_CNT_W-1:0] mf_cnt_next;
  logic sysref_d_reg;
  logic mf_boundary_reg;

  // common part of the checksum, summed at 10 bits so no carry is lost before the final cut
  wire logic [9:0] common_sum;
  wire logic [7:0] chk1_next;
  wire logic [7:0] chk2_next;
  wire logic [7:0] chk3_next;

  assign common_sum = 10'(i_device_id) + 10'(i_bank_id) + 10'(i_scramble) + 10'(i_lanes_m1)
                    + 10'(i_octets_m1) + 10'(i_frames_m1) + 10'(i_converters_m1) + 10'(i_control_bits)
                    + 10'(i_resolution_m1) + 10'(i_subclass) + 10'(i_total_bits_m1) + 10'(i_version)
                    + 10'(i_samples_m1) + 10'(i_high_density) + 10'(i_control_words);
  assign chk1_next = 8'(common_sum + 10'(i_lane1_id)); // RULE8
  assign chk2_next = 8'(common_sum + 10'(i_lane2_id)); // RULE8
  assign chk3_next = 8'(common_sum + 10'(i_lane3_id)); // RULE8

  // one select line per mapped byte, used by the read path and, for the writable bytes, by the write path
  wire logic sel_chk1;
  wire logic sel_chk2;
  wire logic sel_chk3;
  wire logic sel_power_off;
  wire logic sel_map_low;
  wire logic sel_map_high;
  wire logic sel_polarity;
  wire logic sel_phase_offset;

  assign sel_chk1 = (i_reg_addr == ADDR_LANE1_CHECKSUM);
  assign sel_chk2 = (i_reg_addr == ADDR_LANE2_CHECKSUM);
  assign sel_chk3 = (i_reg_addr == ADDR_LANE3_CHECKSUM);
  assign sel_power_off = (i_reg_addr == ADDR_LANE_POWER_OFF);
  assign sel_map_low = (i_reg_addr == ADDR_LANE_MAP_LOW);
  assign sel_map_high = (i_reg_addr == ADDR_LANE_MAP_HIGH);
  assign sel_polarity = (i_reg_addr == ADDR_LANE_POLARITY);
  assign sel_phase_offset = (i_reg_addr == ADDR_MF_PHASE_OFFSET);

  // register decode
  wire logic wr_power_off;
  wire logic wr_map_low;
  wire logic wr_map_high;
  wire logic wr_polarity;
  wire logic wr_phase_offset;
  wire logic [DATA_W-1:0] rdata_next;

  assign wr_power_off = i_reg_wr && sel_power_off;
  assign wr_map_low = i_reg_wr && sel_map_low;
  assign wr_map_high = i_reg_wr && sel_map_high;
  assign wr_polarity = i_reg_wr && sel_polarity;
  assign wr_phase_offset = i_reg_wr && sel_phase_offset;

  // open bits and unmapped addresses read as zero
  assign rdata_next = sel_chk1 ? chk1_reg :
                      sel_chk2 ? chk2_reg :
                      sel_chk3 ? chk3_reg :
                      sel_power_off ? {4'h0, power_off_reg} :
                      sel_map_low ? (map_low_reg & 8'h77) :
                      sel_map_high ? (map_high_reg & 8'h77) :
                      sel_polarity ? {4'h0, polarity_reg} :
                      sel_phase_offset ? {3'h0, phase_offset_reg} : 8'h00;

  // checksum bytes have no write path at all
  always_ff @(posedge i_clk) begin
    chk1_reg <= chk1_next; // RULE1 RULE8
    chk2_reg <= chk2_next; // RULE1 RULE8
    chk3_reg <= chk3_next; // RULE1 RULE8
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      power_off_reg <= RST_LANE_POWER_OFF; // RULE2
      map_low_reg <= RST_LANE_MAP_LOW; // RULE5
      map_high_reg <= RST_LANE_MAP_HIGH; // RULE5
      polarity_reg <= RST_LANE_POLARITY; // RULE6
      phase_offset_reg <= RST_MF_PHASE_OFFSET; // RULE7
      rdata_reg <= 8'h00;
    end else begin
      if (wr_power_off) power_off_reg <= i_reg_wdata[NUM_LANES-1:0]; // RULE2
      if (wr_map_low) map_low_reg <= i_reg_wdata & 8'h77; // RULE5
      if (wr_map_high) map_high_reg <= i_reg_wdata & 8'h77; // RULE5
      if (wr_polarity) polarity_reg <= i_reg_wdata[NUM_LANES-1:0]; // RULE6
      if (wr_phase_offset) phase_offset_reg <= i_reg_wdata[OFFSET_W-1:0]; // RULE7
      if (i_reg_rd) rdata_reg <= rdata_next; // RULE1
    end
  end

  // multiframe phase: a sysref rising edge restarts the phase at the programmed offset
  wire logic sysref_rise;
  assign sysref_rise = i_sysref && !sysref_d_reg;
  // offsets beyond the multiframe length wrap rather than stall the counter
  assign mf_cnt_next = sysref_rise ? MF_CNT_W'(32'(phase_offset_reg) % MF_PERIOD) :
                       (mf_cnt_reg == MF_LAST) ? '0 : MF_CNT_W'(mf_cnt_reg + 1'b1);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sysref_d_reg <= 1'b0;
      mf_cnt_reg <= '0;
      mf_boundary_reg <= 1'b0;
    end else begin
      sysref_d_reg <= i_sysref;
      mf_cnt_reg <= mf_cnt_next; // RULE7
      mf_boundary_reg <= (mf_cnt_next == MF_LAST);
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_mf_boundary = mf_boundary_reg;
  assign o_lane_power_down = power_off_reg; // RULE3
  assign o_lane_invert = polarity_reg; // RULE6
  assign o_lane0_map = map_low_reg[MAP_LO_FIELD_LSB +: MAP_W]; // RULE4
  assign o_lane1_map = map_low_reg[MAP_HI_FIELD_LSB +: MAP_W]; // RULE4
  assign o_lane2_map = map_high_reg[MAP_LO_FIELD_LSB +: MAP_W]; // RULE4
  assign o_lane3_map = map_high_reg[MAP_HI_FIELD_LSB +: MAP_W]; // RULE4

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_chk_write_ignored: assert property ( // RULE1
    (i_reg_wr && i_reg_addr == ADDR_LANE2_CHECKSUM && $stable(chk2_next)) |=> chk2_reg == $past(chk2_reg)
  ) else $error("checksum byte changed on a write");

  a_chk_read_back: assert property ( // RULE1
    (i_reg_rd && i_reg_addr == ADDR_LANE3_CHECKSUM) |=> o_reg_rdata == $past(chk3_reg)
  ) else $error("checksum read returned wrong byte");

  a_chk_follows_params: assert property ( // RULE8
    ##1 (chk1_reg == $past(chk1_next) && chk2_reg == $past(chk2_next) && chk3_reg == $past(chk3_next))
  ) else $error("checksum did not follow link parameters");

  a_power_off_write: assert property ( // RULE2
    wr_power_off |=> o_lane_power_down == $past(i_reg_wdata[3:0])
  ) else $error("lane power-off bits not written");

  a_power_off_hold: assert property ( // RULE3
    (!wr_power_off) |=> $stable(o_lane_power_down)
  ) else $error("lane power-down changed without a write");

  a_map_fields: assert property ( // RULE4
    wr_map_high |=> (o_lane2_map == $past(i_reg_wdata[2:0]) && o_lane3_map == $past(i_reg_wdata[6:4]))
  ) else $error("lane assignment fields misplaced");

  a_map_reset_value: assert property (disable iff (1'b0) // RULE5
    i_rst |=> (o_lane0_map == 3'h0 && o_lane1_map == 3'h1 && o_lane2_map == 3'h2 && o_lane3_map == 3'h3)
  ) else $error("lane assignment not identity after reset");

  a_map_readback: assert property ( // RULE5
    wr_map_low ##1 !i_reg_wr ##1 (i_reg_rd && sel_map_low && !i_reg_wr) |=>
      o_reg_rdata == ($past(i_reg_wdata, 3) & 8'h77)
  ) else $error("lane assignment readback wrong");

  a_polarity_write: assert property ( // RULE6
    wr_polarity |=> o_lane_invert == $past(i_reg_wdata[3:0])
  ) else $error("polarity bits not written");

  a_offset_realign: assert property ( // RULE7
    (sysref_rise && !wr_phase_offset && 32'(phase_offset_reg) < MF_PERIOD) |=>
      32'(mf_cnt_reg) == 32'($past(phase_offset_reg)) ##1 mf_cnt_reg != $past(mf_cnt_reg)
  ) else $error("multiframe phase not loaded with offset");

  a_chk1_read_back: assert property ( // RULE1
    (i_reg_rd && sel_chk1) |=> o_reg_rdata == $past(chk1_reg)
  ) else $error("lane 1 checksum read returned wrong byte");

  a_rdata_hold: assert property ( // RULE1
    (!i_reg_rd) |=> $stable(o_reg_rdata)
  ) else $error("read data changed without a read");

  a_power_off_reset: assert property (disable iff (1'b0) // RULE2
    i_rst |=> o_lane_power_down == 4'h0
  ) else $error("lanes not all enabled after reset");

  a_power_open_bits: assert property ( // RULE2
    (i_reg_rd && sel_power_off) |=> o_reg_rdata[7:4] == 4'h0
  ) else $error("open power-off bits read as one");

  a_polarity_reset: assert property (disable iff (1'b0) // RULE6
    i_rst |=> o_lane_invert == 4'h0
  ) else $error("lanes inverted after reset");

  a_polarity_hold: assert property ( // RULE6
    (!wr_polarity) |=> $stable(o_lane_invert)
  ) else $error("lane inversion changed without a write");

  a_polarity_open_bits: assert property ( // RULE6
    (i_reg_rd && sel_polarity) |=> o_reg_rdata[7:4] == 4'h0
  ) else $error("open polarity bits read as one");

  a_map_low_fields: assert property ( // RULE4
    wr_map_low |=> (o_lane0_map == $past(i_reg_wdata[2:0]) && o_lane1_map == $past(i_reg_wdata[6:4]))
  ) else $error("low pair assignment fields misplaced");

  a_map_hold: assert property ( // RULE5
    !(wr_map_low || wr_map_high) |=> $stable({o_lane3_map, o_lane2_map, o_lane1_map, o_lane0_map})
  ) else $error("lane assignment changed without a write");

  a_map_open_bits: assert property ( // RULE5
    (i_reg_rd && (sel_map_low || sel_map_high)) |=> (o_reg_rdata & 8'h88) == 8'h00
  ) else $error("open assignment bits read as one");

  a_offset_reset: assert property (disable iff (1'b0) // RULE7
    i_rst |=> phase_offset_reg == 5'h00
  ) else $error("phase offset not zero after reset");

  a_offset_write: assert property ( // RULE7
    wr_phase_offset |=> phase_offset_reg == $past(i_reg_wdata[4:0])
  ) else $error("phase offset not written");

  a_offset_open_bits: assert property ( // RULE7
    (i_reg_rd && sel_phase_offset) |=> o_reg_rdata[7:5] == 3'h0
  ) else $error("open offset bits read as one");

  a_offset_wraps: assert property ( // RULE7
    (sysref_rise && 32'(phase_offset_reg) >= MF_PERIOD) |=>
      32'(mf_cnt_reg) == 32'($past(phase_offset_reg)) % MF_PERIOD
  ) else $error("oversized phase offset did not wrap");

  a_boundary_at_last: assert property ( // RULE7
    o_mf_boundary == (mf_cnt_reg == MF_LAST)
  ) else $error("multiframe boundary off its count");

  a_counter_steps: assert property ( // RULE7
    (mf_cnt_reg != MF_LAST && !sysref_rise) |=> 32'(mf_cnt_reg) == 32'($past(mf_cnt_reg)) + 1
  ) else $error("multiframe counter did not step");

  a_counter_wraps: assert property ( // RULE7
    (mf_cnt_reg == MF_LAST && !sysref_rise) |=> mf_cnt_reg == MF_CNT_W'(0)
  ) else $error("multiframe counter did not wrap");

  c_sysref_realign: cover property (sysref_rise && phase_offset_reg != 5'h00);
  c_all_lanes_off: cover property (wr_power_off && i_reg_wdata[3:0] == 4'hf);
  c_remap_write: cover property (wr_map_low && i_reg_wdata == 8'h01);
  c_checksum_read: cover property (i_reg_rd && i_reg_addr == ADDR_LANE1_CHECKSUM);
  c_offset_wrap: cover property (sysref_rise && 32'(phase_offset_reg) >= MF_PERIOD);

endmodule

// ---- verif/lane_rx_model.sv ----
// Purpose: receiver-side model watching multiframe boundaries and lane power state
// Assumes: the boundary is a one-cycle pulse on i_clk
// Notes: o_gap is the spacing of the last two boundaries, zero until the first, which loads the cycles counted since start
module lane_rx_model (
  // clock
  input wire logic i_clk,
  // link side
  input wire logic i_mf_boundary,
  input wire logic [3:0] i_lane_power_down,
  // observation
  output int o_gap,
  output int o_live_lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int gap = 0;
  always @(posedge i_clk) begin
    cnt <= i_mf_boundary ? 1 : cnt + 1;
    if (i_mf_boundary) gap <= cnt;
  end
  assign o_gap = gap;
  // a lane that is powered down carries nothing the receiver could lock to
  assign o_live_lanes = $countones(~i_lane_power_down);
endmodule

// ---- verif/serial_lane_config_regs_tb.sv ----
// Purpose: self-checking bench for the lane configuration register bank
// Assumes: short multiframe of 8 cycles so realignment runs stay brief
// Notes: link parameters are random and masked to their port widths
module serial_lane_config_regs_tb;
  import serial_lane_config_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MFP = 8;
  localparam int W[15] = '{8, 4, 1, 5, 8, 5, 8, 2, 5, 3, 5, 3, 5, 1, 5};
  logic i_clk = 0, i_rst = 1, wr = 0, rd = 0, sysref = 0, mfb;
  logic [7:0] addr = 0, wdata = 0, rdat, d, f[15], id[1:3];
  logic [3:0] pd, inv;
  logic [2:0] m0, m1, m2, m3;
  int n_errors = 0, num_checks = 0, seed = 44, gap, live, n;
  always #5 i_clk = ~i_clk;
  serial_lane_config_regs #(.MF_PERIOD(MFP)) i_serial_lane_config_regs (.i_clk(i_clk), .i_rst(i_rst),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdat),
    .i_device_id(f[0]), .i_bank_id(f[1][3:0]), .i_scramble(f[2][0]), .i_lanes_m1(f[3][4:0]),
    .i_octets_m1(f[4]), .i_frames_m1(f[5][4:0]), .i_converters_m1(f[6]), .i_control_bits(f[7][1:0]),
    .i_resolution_m1(f[8][4:0]), .i_subclass(f[9][2:0]), .i_total_bits_m1(f[10][4:0]),
    .i_version(f[11][2:0]), .i_samples_m1(f[12][4:0]), .i_high_density(f[13][0]),
    .i_control_words(f[14][4:0]), .i_lane1_id(id[1][4:0]), .i_lane2_id(id[2][4:0]),
    .i_lane3_id(id[3][4:0]), .i_sysref(sysref), .o_mf_boundary(mfb), .o_lane_power_down(pd),
    .o_lane_invert(inv), .o_lane0_map(m0), .o_lane1_map(m1), .o_lane2_map(m2), .o_lane3_map(m3));
  lane_rx_model i_lane_rx_model (.i_clk(i_clk), .i_mf_boundary(mfb), .i_lane_power_down(pd),
    .o_gap(gap), .o_live_lanes(live));
  function automatic logic [7:0] exp_sum(int lane);
    logic [7:0] s;
    s = id[lane];
    for (int i = 0; i < 15; i++) s = s + f[i];
    return s;
  endfunction
  task automatic randomize_params();
    for (int i = 0; i < 15; i++) f[i] = $random(seed) & ((1 << W[i]) - 1);
    for (int i = 1; i < 4; i++) id[i] = $random(seed) & 8'h1f;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk) addr = a;
    wdata = v;
    wr = 1;
    @(negedge i_clk) wr = 0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_clk) addr = a;
    rd = 1;
    @(negedge i_clk) rd = 0;
    v = rdat;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    logic [7:0] v[4];
    randomize_params();
    repeat (10) @(negedge i_clk);
    i_rst = 0;
    reg_rd(ADDR_LANE_POWER_OFF, d); check(d, 8'h00);
    reg_rd(ADDR_LANE_MAP_LOW, d); check(d, 8'h10);
    reg_rd(ADDR_LANE_MAP_HIGH, d); check(d, 8'h32);
    reg_rd(ADDR_LANE_POLARITY, d); check(d, 8'h00);
    reg_rd(ADDR_MF_PHASE_OFFSET, d); check(d, 8'h00);
    check({m3[1:0], m2[1:0], m1[1:0], m0[1:0]}, 8'he4);
    reg_rd(8'h81, d); check(d, 8'h00);
    // two passes so the checksums must follow a parameter change
    repeat (2) begin
      randomize_params();
      for (int l = 1; l < 4; l++) begin
        reg_wr(8'(ADDR_LANE1_CHECKSUM + l - 1), ~exp_sum(l));
        reg_rd(8'(ADDR_LANE1_CHECKSUM + l - 1), d); check(d, exp_sum(l));
      end
    end
    for (int k = 0; k < 20; k++) begin
      for (int j = 0; j < 4; j++) v[j] = $random(seed);
      if (k == 0) v[0] = 8'hff;
      if (k == 0) v[2] = 8'h01;
      reg_wr(ADDR_LANE_POWER_OFF, v[0]);
      reg_wr(ADDR_LANE_POLARITY, v[1]);
      reg_wr(ADDR_LANE_MAP_LOW, v[2]);
      reg_wr(ADDR_LANE_MAP_HIGH, v[3]);
      reg_wr(8'h81, 8'hff);
      check(pd, v[0][3:0]);
      check(live, 4 - $countones(v[0][3:0]));
      check(inv, v[1][3:0]);
      check({m1, 1'b0, m0}, v[2] & 8'h77);
      check({m3, 1'b0, m2}, v[3] & 8'h77);
      reg_rd(ADDR_LANE_POWER_OFF, d); check(d, v[0] & 8'h0f);
      reg_rd(ADDR_LANE_POLARITY, d); check(d, v[1] & 8'h0f);
      reg_rd(ADDR_LANE_MAP_LOW, d); check(d, v[2] & 8'h77);
      reg_rd(ADDR_LANE_MAP_HIGH, d); check(d, v[3] & 8'h77);
      // write then read straight after, one idle cycle between
      reg_wr(ADDR_LANE_MAP_LOW, v[2] ^ 8'h11);
      reg_rd(ADDR_LANE_MAP_LOW, d); check(d, (v[2] ^ 8'h11) & 8'h77);
    end
    reg_wr(ADDR_MF_PHASE_OFFSET, 8'hff);
    reg_rd(ADDR_MF_PHASE_OFFSET, d); check(d, 8'h1f);
    // offsets at zero, at 3, at the last count and past the period
    foreach (v[j]) begin
      d = (j == 0) ? 8'h00 : (j == 1) ? 8'h03 : (j == 2) ? 8'(MFP - 1) : 8'(MFP + 1);
      reg_wr(ADDR_MF_PHASE_OFFSET, d);
      @(negedge i_clk) sysref = 1;
      @(negedge i_clk) n = 0;
      while (mfb !== 1'b1 && n < 40) begin
        @(negedge i_clk) n++;
      end
      check(n, MFP - 1 - (d % MFP));
      repeat (2 * MFP + 1) @(negedge i_clk);
      check(gap, MFP);
      sysref = 0;
    end
    // a reset in mid-run must bring back every default over written values
    reg_wr(ADDR_LANE_POWER_OFF, 8'h0a);
    reg_wr(ADDR_LANE_POLARITY, 8'h05);
    @(negedge i_clk) i_rst = 1;
    repeat (2) @(negedge i_clk);
    i_rst = 0;
    check(pd, 8'h00);
    check(inv, 8'h00);
    check({m1, 1'b0, m0}, 8'h10);
    check({m3, 1'b0, m2}, 8'h32);
    reg_rd(ADDR_MF_PHASE_OFFSET, d); check(d, 8'h00);
    report_and_stop();
  end
endmodule
